// >>> design/sar_adc_parallel_readout.sv
/*
  conversion handshake and parallel result readout of a 16-bit sampling
  converter: start detection, active-low busy flag, result register,
  byte-selectable three-state result bus, and a result fifo between the
  successive-approximation core and the result register.
  assumes the host pins are asynchronous and the core answers each
  conv_start with one word well inside the conversion window.
*/
//
// Contract
// (RULE1) when the result register holds the new word, busy rises and the word is on result_bus.
// (RULE2) the previous result stays readable for at least 5 us after a new start.
// (RULE3) the host does not read from 5 us after a start until busy rises.
// (RULE4) the host should avoid reading during a conversion.
// (RULE5) the host may hold chip select low and use the read/convert strobe alone.
// (RULE6) busy falls as soon as possible after the start condition is seen.
// (RULE7) the new result is valid and busy ends within 8 us of the start.
// (RULE8) busy rises at least 50 ns after the new result is valid.
// (RULE9) the host latches results externally if its bus is busy during conversions.
// (RULE10) both strobes low for 40 ns starts a conversion; starts while busy are ignored.
// (RULE11) the bus is driven only while read/convert is high and chip select low.
// (RULE12) the result reads as one word or as two bytes chosen by byte select.
// (RULE13) the host raises a strobe before busy rises, else a new conversion starts at once.
// (RULE14) the host spaces starts at least 10 us apart.
`timescale 1ns/1ps

// ============================================================
// result fifo
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          room;
  } fifo_state_type;

  fifo_state_type   st;
  fifo_state_type   next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // registered so the ready output leaves a flip-flop
  assign in_ready  = st.room;
  assign out_valid = (st.count != '0);
  assign out_data  = mem[st.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
    next_st.room = (next_st.count != (AW+1)'(DEPTH));
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st      <= '0;
      st.room <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[st.wr_ptr] <= in_data;
    end
  end
endmodule // result_fifo

// ============================================================
// top level
module sar_adc_parallel_readout
  import sar_readout_pkg::*;
#(
  parameter int FIFO_W = RESULT_W,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic                chip_sel_n,
  input  wire logic                read_conv_n,
  input  wire logic                byte_sel,
  output logic                     busy_n,
  output logic [RESULT_W-1:0]      result_bus,
  output logic                     result_bus_oe,
  output logic                     conv_start,
  input  wire logic [RESULT_W-1:0] core_data,
  input  wire logic                core_valid,
  output logic                     core_ready
);

  typedef struct packed {
    logic [1:0]          cs_sync;
    logic [1:0]          rc_sync;
    logic [1:0]          byte_sync;
    conv_state_type      state;
    logic [CNT_W-1:0]    timer;
    logic [CNT_W-1:0]    low_cnt;
    logic [RESULT_W-1:0] result;
    logic                busy_n;
    logic [RESULT_W-1:0] bus;
    logic                oe;
    logic                start;
  } top_state_type;

  top_state_type       st;
  top_state_type       next_st;
  logic [RESULT_W-1:0] fifo_data;
  logic                fifo_valid;
  logic                fifo_pop;
  logic                cs_low;
  logic                rc_low;

  // ==========================================================
  // core results queue up until the load point
  result_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_data   (core_data),
    .in_valid  (core_valid),
    .in_ready  (core_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // only the second sync stage is read
  assign cs_low   = !st.cs_sync[1];
  assign rc_low   = !st.rc_sync[1];
  assign fifo_pop = (st.state == ST_CONVERT) && fifo_valid &&
                    (st.timer >= CNT_W'(LOAD_CYC));

  function automatic logic [RESULT_W-1:0] lane_map(
    input logic [RESULT_W-1:0] word,
    input logic                swap);
    lane_map = swap ? {word[BYTE_W-1:0], word[RESULT_W-1:BYTE_W]} : word;
  endfunction

  // ==========================================================
  // control
  always_comb begin
    next_st = st;
    next_st.cs_sync   = {st.cs_sync[0], chip_sel_n};
    next_st.rc_sync   = {st.rc_sync[0], read_conv_n};
    next_st.byte_sync = {st.byte_sync[0], byte_sel};
    next_st.start     = 1'b0;
    // saturates at all ones, where low_cnt + 1 in the start check wraps to zero, below the minimum
    next_st.low_cnt   = !(cs_low && rc_low) ? '0 :
                        (st.low_cnt == '1) ? st.low_cnt : st.low_cnt + 1'b1;
    next_st.timer     = st.timer + 1'b1;
    unique case (st.state)
      ST_IDLE: begin
        // level triggered; commands while busy never reach here [RULE10]
        if (cs_low && rc_low &&
            (st.low_cnt + 1'b1 >= CNT_W'(START_MIN_CYC))) begin
          next_st.state  = ST_CONVERT;
          next_st.busy_n = 1'b0; // [RULE6]
          next_st.start  = 1'b1;
          next_st.timer  = '0;
        end
      end
      ST_CONVERT: begin
        // old result held until the load point, past 5 us [RULE2]
        if (fifo_pop) begin
          next_st.result = fifo_data; // [RULE7]
          next_st.state  = ST_SETTLE;
          next_st.timer  = '0;
        end
      end
      ST_SETTLE: begin
        // one cycle for the word to reach the bus, then the lag [RULE8]
        if (st.timer >= CNT_W'(BUSY_LAG_CYC)) begin
          next_st.busy_n = 1'b1; // [RULE8] [RULE1]
          next_st.state  = ST_IDLE;
        end
      end
    endcase
    // drive only for read/convert high and chip select low [RULE11]
    next_st.oe  = st.rc_sync[1] && cs_low;
    // word or swapped byte lanes [RULE12]
    next_st.bus = lane_map(st.result, st.byte_sync[1]); // [RULE1]
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st        <= '0;
      st.cs_sync   <= 2'h3;
      st.rc_sync   <= 2'h3;
      st.state     <= ST_IDLE;
      st.result    <= RESULT_RST;
      st.bus       <= RESULT_RST;
      st.busy_n    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign busy_n        = st.busy_n;
  assign result_bus    = st.bus;
  assign result_bus_oe = st.oe;
  assign conv_start    = st.start;

endmodule // sar_adc_parallel_readout

// >>> design/sar_readout_pkg.sv
/*
  constants shared by the parallel readout logic of the sampling converter.
  assumes a 10 mhz system clock.
*/
package sar_readout_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS       = 100;
  localparam int CONV_MAX_NS         = 8000;
  localparam int PREV_VALID_NS       = 5000;
  localparam int BUSY_LAG_MIN_NS     = 50;
  localparam int START_PULSE_MIN_NS  = 40;

  // longest times round down, least times round up, never below one
  localparam int CONV_MAX_CYC   = (CONV_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int PREV_VALID_CYC = (PREV_VALID_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  PREV_VALID_NS / CLK_PERIOD_NS;
  localparam int BUSY_LAG_CYC   = (BUSY_LAG_MIN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int START_MIN_CYC  = (START_PULSE_MIN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  // latest load cycle: one cycle to reach the bus, then the busy lag
  localparam int LOAD_CYC       = CONV_MAX_CYC - BUSY_LAG_CYC - 2;

  // ==========================================================
  // widths and reset values
  localparam int RESULT_W       = 16;
  localparam int BYTE_W         = 8;
  localparam int FIFO_DEPTH     = 16;
  localparam int CNT_W          = 8;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_SETTLE
  } conv_state_type;

endpackage

// >>> verif/sar_core_model.sv
/* core stand-in: a word DELAY cycles after conv_start, or a word every
   other cycle while flood is high; assumes the readout's clock and reset */
`timescale 1ns/1ps
module sar_core_model #(parameter int DELAY = 40) (
  input  wire logic sys_clk, sys_rst, flood, conv_start, core_ready,
  output logic [15:0] core_data,
  output logic core_valid);
  logic [15:0] word;
  int cnt;
  always @(posedge sys_clk) begin
    cnt <= conv_start ? DELAY : cnt - 1;
    if (sys_rst) begin
      word <= 16'h1234;
      core_valid <= 1'b0;
    end else if (core_valid && core_ready) begin
      core_valid <= 1'b0;
      word <= word + 16'h0f0f;
    end else if (flood || cnt == 1)
      core_valid <= 1'b1;
  end
  // released data lines carry no stale word
  assign core_data = core_valid ? word : ~word;
endmodule // sar_core_model

// >>> verif/sar_readout_props.sv
/* pin checks of the readout; assumes binding into its top module */
`timescale 1ns/1ps
module sar_readout_props import sar_readout_pkg::*; (
  input wire logic sys_clk, sys_rst, chip_sel_n, read_conv_n, byte_sel,
  input wire logic busy_n, result_bus_oe, conv_start,
  input wire logic [15:0] result_bus);
  wire rd = !chip_sel_n && read_conv_n;
  wire cv = !chip_sel_n && !read_conv_n;
  // cycles since busy fell
  int low_cyc;
  always @(posedge sys_clk)
    low_cyc <= (sys_rst || busy_n) ? 0 : low_cyc + 1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_fall; $fell(busy_n) == conv_start; endproperty
  a_fall: assert property (p_fall) else $error("busy fall");
  property p_pulse; conv_start |=> !conv_start; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_max; $fell(busy_n) |-> ##[1:80] busy_n; endproperty
  a_max: assert property (p_max) else $error("busy long");
  property p_min; $fell(busy_n) |=> !busy_n [*8]; endproperty
  a_min: assert property (p_min) else $error("busy short");
  property p_cause; conv_start |-> $past(busy_n) && $past(cv, 2); endproperty
  a_cause: assert property (p_cause) else $error("start");
  property p_held; !busy_n && low_cyc < PREV_VALID_CYC
    && $past(byte_sel, 3) == $past(byte_sel, 4) |-> $stable(result_bus);
  endproperty
  a_held: assert property (p_held) else $error("old word");
  property p_oe; result_bus_oe |-> $past(rd, 3); endproperty
  a_oe: assert property (p_oe) else $error("bus driven");
  property p_again; $rose(busy_n) && cv && $past(cv) && $past(cv, 2)
    |-> ##[1:3] conv_start;
  endproperty
  a_again: assert property (p_again) else $error("restart");
  property p_lag; $rose(busy_n) && $past(byte_sel, 3) == $past(byte_sel, 4)
    |-> $stable(result_bus);
  endproperty
  a_lag: assert property (p_lag) else $error("busy early");
endmodule // sar_readout_props

bind sar_adc_parallel_readout sar_readout_props sar_readout_props_i (
  .sys_clk, .sys_rst, .chip_sel_n, .read_conv_n, .byte_sel, .busy_n,
  .result_bus_oe, .conv_start, .result_bus);

// >>> verif/tb_sar_adc_parallel_readout.sv
/* bench of the readout; assumes pins driven at the falling edge */
`timescale 1ns/1ps
`define check(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
  n_errors++; $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_sar_adc_parallel_readout;
  import sar_readout_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, chip_sel_n = 1'b0;
  logic read_conv_n = 1'b1, byte_sel = 1'b0, flood = 1'b0;
  logic busy_n, result_bus_oe, conv_start, core_valid, core_ready;
  logic [15:0] result_bus, core_data, word = RESULT_RST, nxt = 16'h1234;
  logic [15:0] latched;
  int n_errors = 0, n_compared = 0, n_starts = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    n_starts <= n_starts + int'(conv_start === 1'b1);
  always @(posedge busy_n) latched <= result_bus;
  sar_adc_parallel_readout sar_adc_parallel_readout_i (.sys_clk, .sys_rst,
    .chip_sel_n, .read_conv_n, .byte_sel, .busy_n, .result_bus,
    .result_bus_oe, .conv_start, .core_data, .core_valid, .core_ready);
  sar_core_model sar_core_model_i (.sys_clk, .sys_rst, .flood,
    .conv_start, .core_ready, .core_data, .core_valid);
  task automatic complete_run(input int bad);
    n_errors += bad;
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wait_busy(input logic lvl, output int t);
    for (t = 0; busy_n !== lvl; t++) begin
      if (t > 200) complete_run(1);
      @(negedge sys_clk);
    end
  endtask
  task automatic s_convert(input logic poke);
    int t, s0;
    s0 = n_starts;
    read_conv_n = 1'b0;
    cycles(3);
    `check("oe", 1'b0, result_bus_oe)
    read_conv_n = 1'b1;
    if (poke) begin
      cycles(20);
      `check("old", word, result_bus)
      read_conv_n = 1'b0;
      cycles(3);
      read_conv_n = 1'b1;
    end
    wait_busy(1'b1, t);
    `check("time", 1'b1, t <= CONV_MAX_CYC)
    `check("new", nxt, result_bus)
    `check("on", 1'b1, result_bus_oe)
    `check("starts", s0 + 1, n_starts)
    `check("latch", nxt, latched)
    word = nxt;
    nxt = nxt + 16'h0f0f;
    cycles(20);
  endtask
  task automatic s_bytes;
    byte_sel = 1'b1;
    cycles(4);
    `check("swap", {word[7:0], word[15:8]}, result_bus)
    byte_sel = 1'b0;
    chip_sel_n = 1'b1;
    cycles(4);
    `check("off", 1'b0, result_bus_oe)
    chip_sel_n = 1'b0;
  endtask
  task automatic s_hold;
    int t;
    flood = 1'b1;
    read_conv_n = 1'b0;
    cycles(40);
    `check("full", 1'b0, core_ready)
    `check("kept", word, result_bus)
    flood = 1'b0;
    wait_busy(1'b1, t);
    cycles(4);
    `check("restart", 1'b0, busy_n)
    read_conv_n = 1'b1;
    wait_busy(1'b1, t);
    `check("second", nxt + 16'h0f0f, result_bus)
  endtask
  initial begin
    cycles(16);
    sys_rst = 1'b0;
    cycles(4);
    s_convert(1'b0);
    s_bytes();
    s_convert(1'b1);
    s_hold();
    complete_run(0);
  end
endmodule // tb_sar_adc_parallel_readout
